// ===== pkg/ots_cfg.svh
// constants and register map of the output terminal function selector
// Summary of operation
// - code 13 on during pre-excitation
// - codes 14/15 after pre-alarm time elapsed
// - codes 16/17 sequencer stage and cycle done
// - codes 23-25 follow link virtual bits
// - code 26 on above undervoltage threshold
// - code 27 on at index, off 10 ms later
// - code 28 on during pulse superposition
// - code 29 on during safe torque off fault
// - codes 30-32 positioning and spindle done
// - code 33 on while speed limit clamps
// - code 34 follows ethernet fieldbus virtual bit
// - code 36 on after control switchover done
// - code 37 on above frequency detection value
// - codes 41-47 pass expansion card outputs
// - codes 48-50 overheat pre-alarm sources
// - code 51 on when stopped or zero speed
// - code 52 tension disconnection when enabled
// - codes 53-55 roll diameter during tension running
// - code 56 on while fire mode on
// - fast output type 0 selects pulse output
// - code 0 off; codes 1-4 running states
// - code 12 on when ready to run
// - outputs may share codes independently
`ifndef OTS_CFG_SVH
`define OTS_CFG_SVH

`define OTS_ADDR_W        8
`define OTS_DATA_W        32
`define OTS_CODE_W        6
`define OTS_NUM_OUT       4
`define OTS_TIME_W        16
`define OTS_MS_W          18
`define OTS_Z_W           21
`define OTS_CARD_W        7

`define OTS_ADDR_CTRL     8'h00
`define OTS_ADDR_SEL0     8'h04
`define OTS_ADDR_SEL1     8'h08
`define OTS_ADDR_SEL2     8'h0c
`define OTS_ADDR_SEL3     8'h10
`define OTS_ADDR_OL_TIME  8'h14
`define OTS_ADDR_UL_TIME  8'h18
`define OTS_ADDR_STATUS   8'h1c

`define OTS_RST_FAST_TYPE 1'h0
`define OTS_RST_SEL0      6'h00
`define OTS_RST_SEL1      6'h00
`define OTS_RST_SEL2      6'h01
`define OTS_RST_SEL3      6'h05
`define OTS_RST_TIME      16'h0000

`define OTS_CODE_NONE     6'h00
`define OTS_CLK_NS        5
`define OTS_MS_NS         1000000
`define OTS_Z_PULSE_NS    10000000

`endif

// ===== pkg/ots_pkg.sv
// types of the output terminal function selector
`include "ots_cfg.svh"
package ots_pkg;
   typedef logic [`OTS_ADDR_W-1:0] ots_addr_t;
   typedef logic [`OTS_DATA_W-1:0] ots_data_t;
   typedef logic [`OTS_CODE_W-1:0] ots_code_t;

   typedef struct packed {
      logic                                fast_type;
      logic [`OTS_NUM_OUT-1:0][`OTS_CODE_W-1:0] sel;
      logic [`OTS_TIME_W-1:0]              ol_time;
      logic [`OTS_TIME_W-1:0]              ul_time;
      logic [`OTS_TIME_W-1:0]              ol_ms;
      logic [`OTS_TIME_W-1:0]              ul_ms;
      logic                                ol_alm;
      logic                                ul_alm;
      logic [`OTS_MS_W-1:0]                ms_cnt;
      logic [`OTS_Z_W-1:0]                 z_cnt;
      logic                                z_act;
      logic                                enc_q;
      logic [`OTS_NUM_OUT-1:0]             pin;
      ots_data_t                           rdata;
   } ots_state_t;
endpackage : ots_pkg

// ===== rtl/ots_select.sv
// output terminal function selector with register port
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ots_cfg.svh"
module ots_select #(
   parameter int unsigned MS_CYC = `OTS_MS_NS / `OTS_CLK_NS,
   parameter int unsigned Z_CYC  = `OTS_Z_PULSE_NS / `OTS_CLK_NS
) (
   input  wire logic               core_clk_i,
   input  wire logic               reset_n_i,
   input  wire ots_pkg::ots_addr_t addr_i,
   input  wire ots_pkg::ots_data_t wdata_i,
   input  wire logic               wr_i,
   input  wire logic               rd_i,
   output      ots_pkg::ots_data_t rdata_o,
   input  wire logic               run_freq_i,
   input  wire logic               run_fwd_i,
   input  wire logic               run_rev_i,
   input  wire logic               jog_i,
   input  wire logic               fault_i,
   input  wire logic               fdt1_i,
   input  wire logic               fdt2_i,
   input  wire logic               freq_reached_i,
   input  wire logic               zero_speed_run_i,
   input  wire logic               upper_lim_i,
   input  wire logic               lower_lim_i,
   input  wire logic               ready_i,
   input  wire logic               pre_excite_i,
   input  wire logic               overload_i,
   input  wire logic               underload_i,
   input  wire logic               seq_stage_done_i,
   input  wire logic               seq_cycle_done_i,
   input  wire logic               count_set_i,
   input  wire logic               count_desig_i,
   input  wire logic               ext_fault_i,
   input  wire logic               run_time_i,
   input  wire logic               vbit_serial_i,
   input  wire logic               vbit_fieldbus_i,
   input  wire logic               vbit_eth_i,
   input  wire logic               dc_bus_ok_i,
   input  wire logic               enc_index_i,
   input  wire logic               pulse_superpos_i,
   input  wire logic               safe_torque_off_i,
   input  wire logic               pos_done_i,
   input  wire logic               spindle_zero_i,
   input  wire logic               spindle_div_i,
   input  wire logic               speed_limit_i,
   input  wire logic               vbit_indeth_i,
   input  wire logic               switchover_done_i,
   input  wire logic               ramp_above_i,
   input  wire logic [6:0]         expansion_card_i,
   input  wire logic               overheat_pt100_i,
   input  wire logic               overheat_pt1000_i,
   input  wire logic               overheat_aio_i,
   input  wire logic               stopped_zero_i,
   input  wire logic               tension_disc_en_i,
   input  wire logic               tension_disc_i,
   input  wire logic               tension_run_i,
   input  wire logic               roll_set_i,
   input  wire logic               roll_max_i,
   input  wire logic               roll_min_i,
   input  wire logic               fire_mode_i,
   input  wire logic               pulse_stream_i,
   output      logic               collector_out_1_o,
   output      logic               fast_pulse_out_o,
   output      logic               relay_out_1_o,
   output      logic               relay_out_2_o
);
   import ots_pkg::*;

   ots_state_t r;
   ots_state_t next_r;
   logic [63:0] cv;
   logic        ms_tick;
   logic        enc_rise;

   // condition vector indexed by function code, 63 down to 0
   always_comb begin
      cv = {
         7'h00,
         fire_mode_i,
         tension_run_i & roll_min_i,
         tension_run_i & roll_max_i,
         tension_run_i & roll_set_i,
         tension_disc_en_i & tension_disc_i,
         stopped_zero_i,
         overheat_aio_i,
         overheat_pt1000_i,
         overheat_pt100_i,
         expansion_card_i,
         3'h0,
         ramp_above_i,
         switchover_done_i,
         1'b0,
         vbit_indeth_i,
         speed_limit_i,
         spindle_div_i,
         spindle_zero_i,
         pos_done_i,
         safe_torque_off_i,
         pulse_superpos_i,
         r.z_act,
         dc_bus_ok_i,
         vbit_eth_i,
         vbit_fieldbus_i,
         vbit_serial_i,
         run_time_i,
         1'b0,
         ext_fault_i,
         count_desig_i,
         count_set_i,
         seq_cycle_done_i,
         seq_stage_done_i,
         r.ul_alm,
         r.ol_alm,
         pre_excite_i,
         ready_i,
         lower_lim_i,
         upper_lim_i,
         zero_speed_run_i,
         freq_reached_i,
         fdt2_i,
         fdt1_i,
         fault_i,
         jog_i,
         run_rev_i,
         run_fwd_i,
         run_freq_i,
         1'b0
      };
   end

   assign ms_tick  = (r.ms_cnt == `OTS_MS_W'(MS_CYC - 1));
   assign enc_rise = enc_index_i & ~r.enc_q;

   always_comb begin
      next_r = r;
      next_r.rdata = '0;
      // register writes
      if (wr_i) begin
         unique case (addr_i)
            `OTS_ADDR_CTRL:    next_r.fast_type = wdata_i[0];
            `OTS_ADDR_SEL0:    next_r.sel[0] = wdata_i[`OTS_CODE_W-1:0];
            `OTS_ADDR_SEL1:    next_r.sel[1] = wdata_i[`OTS_CODE_W-1:0];
            `OTS_ADDR_SEL2:    next_r.sel[2] = wdata_i[`OTS_CODE_W-1:0];
            `OTS_ADDR_SEL3:    next_r.sel[3] = wdata_i[`OTS_CODE_W-1:0];
            `OTS_ADDR_OL_TIME: next_r.ol_time = wdata_i[`OTS_TIME_W-1:0];
            `OTS_ADDR_UL_TIME: next_r.ul_time = wdata_i[`OTS_TIME_W-1:0];
            default: ;
         endcase
      end
      // register reads, unmapped addresses read zero
      if (rd_i) begin
         unique case (addr_i)
            `OTS_ADDR_CTRL:    next_r.rdata = `OTS_DATA_W'(r.fast_type);
            `OTS_ADDR_SEL0:    next_r.rdata = `OTS_DATA_W'(r.sel[0]);
            `OTS_ADDR_SEL1:    next_r.rdata = `OTS_DATA_W'(r.sel[1]);
            `OTS_ADDR_SEL2:    next_r.rdata = `OTS_DATA_W'(r.sel[2]);
            `OTS_ADDR_SEL3:    next_r.rdata = `OTS_DATA_W'(r.sel[3]);
            `OTS_ADDR_OL_TIME: next_r.rdata = `OTS_DATA_W'(r.ol_time);
            `OTS_ADDR_UL_TIME: next_r.rdata = `OTS_DATA_W'(r.ul_time);
            `OTS_ADDR_STATUS:
               next_r.rdata = `OTS_DATA_W'({r.z_act, r.ul_alm, r.ol_alm, r.pin});
            default:           next_r.rdata = '0;
         endcase
      end

      // one millisecond time base for the pre-alarm timers
      next_r.ms_cnt = ms_tick ? '0 : r.ms_cnt + `OTS_MS_W'(1);

      // pre-alarm needs the load past threshold for the whole time
      if (!overload_i) begin
         next_r.ol_ms  = '0;
         next_r.ol_alm = 1'b0;
      end else if (ms_tick) begin
         if (r.ol_ms >= r.ol_time)
            next_r.ol_alm = 1'b1;
         else
            next_r.ol_ms = r.ol_ms + `OTS_TIME_W'(1);
      end
      if (!underload_i) begin
         next_r.ul_ms  = '0;
         next_r.ul_alm = 1'b0;
      end else if (ms_tick) begin
         if (r.ul_ms >= r.ul_time)
            next_r.ul_alm = 1'b1;
         else
            next_r.ul_ms = r.ul_ms + `OTS_TIME_W'(1);
      end

      // index pulse stretch; a new index restarts the window
      next_r.enc_q = enc_index_i;
      if (enc_rise) begin
         next_r.z_act = 1'b1;
         next_r.z_cnt = `OTS_Z_W'(Z_CYC - 1);
      end else if (r.z_act) begin
         if (r.z_cnt == '0)
            next_r.z_act = 1'b0;
         else
            next_r.z_cnt = r.z_cnt - `OTS_Z_W'(1);
      end

      // each output decodes its own code, so shared codes are fine
      for (int i = 0; i < `OTS_NUM_OUT; i++) begin
         next_r.pin[i] = cv[r.sel[i]];
      end
      // pulse mode bypasses the function selection
      if (!r.fast_type)
         next_r.pin[1] = pulse_stream_i;
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r           <= '0;
         r.fast_type <= `OTS_RST_FAST_TYPE;
         r.sel[0]    <= `OTS_RST_SEL0;
         r.sel[1]    <= `OTS_RST_SEL1;
         r.sel[2]    <= `OTS_RST_SEL2;
         r.sel[3]    <= `OTS_RST_SEL3;
         r.ol_time   <= `OTS_RST_TIME;
         r.ul_time   <= `OTS_RST_TIME;
      end else begin
         r <= next_r;
      end
   end

   assign rdata_o           = r.rdata;
   assign collector_out_1_o = r.pin[0];
   assign fast_pulse_out_o  = r.pin[1];
   assign relay_out_1_o     = r.pin[2];
   assign relay_out_2_o     = r.pin[3];

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   AST_NO_FUNC: assert property (
      (r.sel[0] == `OTS_CODE_NONE) |=> !collector_out_1_o)
      else $error("code 0 output not off");

   AST_RESERVED: assert property (
      (r.sel[2] == 6'h23 || (r.sel[2] >= 6'h26 && r.sel[2] <= 6'h28)
       || r.sel[2] >= 6'h39) |=> !relay_out_1_o)
      else $error("reserved code output not off");

   AST_PRE_EXCITE: assert property (
      (r.sel[0] == 6'h0d) |=> (collector_out_1_o == $past(pre_excite_i)))
      else $error("pre-excitation output mismatch");

   AST_VBIT: assert property (
      (r.sel[3] == 6'h17) |=> (relay_out_2_o == $past(vbit_serial_i)))
      else $error("virtual bit output mismatch");

   AST_OL_DELAY: assert property (
      $rose(r.ol_alm) |-> $past(overload_i) && $past(r.ol_ms) >= $past(r.ol_time))
      else $error("overload pre-alarm too early");

   AST_Z_START: assert property (
      enc_rise |=> r.z_act && r.z_cnt == `OTS_Z_W'(Z_CYC - 1))
      else $error("index pulse window not started");

   AST_Z_END: assert property (
      (r.z_act && r.z_cnt == '0 && !enc_rise) |=> !r.z_act)
      else $error("index pulse window not ended");

   AST_FAST_PULSE: assert property (
      !r.fast_type |=> (fast_pulse_out_o == $past(pulse_stream_i)))
      else $error("fast output not in pulse mode");

   AST_CARD: assert property (
      (r.sel[3] == 6'h2b) |=> (relay_out_2_o == $past(expansion_card_i[2])))
      else $error("card pass-through mismatch");

   AST_SHARED: assert property (
      (r.sel[2] == r.sel[3]) |=> (relay_out_1_o == relay_out_2_o))
      else $error("shared code outputs differ");

   AST_RESET_OFF: assert property (
      $rose(reset_n_i) |-> !collector_out_1_o && !fast_pulse_out_o && !relay_out_1_o
         && !relay_out_2_o && rdata_o == '0)
      else $error("outputs not off after reset");

   AST_UL_DELAY: assert property (
      $rose(r.ul_alm) |-> $past(underload_i) && $past(r.ul_ms) >= $past(r.ul_time))
      else $error("underload pre-alarm too early");

   AST_READY: assert property (
      (r.sel[0] == 6'h0c) |=> (collector_out_1_o == $past(ready_i)))
      else $error("ready output mismatch");

   AST_SEQ_STAGE: assert property (
      (r.sel[0] == 6'h10) |=> (collector_out_1_o == $past(seq_stage_done_i)))
      else $error("sequencer stage output mismatch");

   AST_SEQ_CYCLE: assert property (
      (r.fast_type && r.sel[1] == 6'h11) |=> (fast_pulse_out_o == $past(seq_cycle_done_i)))
      else $error("sequencer cycle output mismatch");

   AST_VBIT_BUS: assert property (
      (r.sel[0] == 6'h18) |=> (collector_out_1_o == $past(vbit_fieldbus_i)))
      else $error("fieldbus virtual bit output mismatch");

   AST_DC_BUS: assert property (
      (r.sel[2] == 6'h1a) |=> (relay_out_1_o == $past(dc_bus_ok_i)))
      else $error("bus voltage output mismatch");

   AST_SUPERPOS: assert property (
      (r.sel[0] == 6'h1c) |=> (collector_out_1_o == $past(pulse_superpos_i)))
      else $error("pulse superposition output mismatch");

   AST_STO: assert property (
      (r.sel[0] == 6'h1d) |=> (collector_out_1_o == $past(safe_torque_off_i)))
      else $error("safe torque off output mismatch");

   AST_POS_DONE: assert property (
      (r.sel[2] == 6'h1e) |=> (relay_out_1_o == $past(pos_done_i)))
      else $error("positioning output mismatch");

   AST_SPINDLE: assert property (
      (r.sel[3] == 6'h1f) |=> (relay_out_2_o == $past(spindle_zero_i)))
      else $error("spindle zeroing output mismatch");

   AST_SPEED_LIM: assert property (
      (r.fast_type && r.sel[1] == 6'h21) |=> (fast_pulse_out_o == $past(speed_limit_i)))
      else $error("speed limit output mismatch");

   AST_ETH_BIT: assert property (
      (r.sel[2] == 6'h22) |=> (relay_out_1_o == $past(vbit_indeth_i)))
      else $error("ethernet virtual bit output mismatch");

   AST_SWITCHOVER: assert property (
      (r.sel[0] == 6'h24) |=> (collector_out_1_o == $past(switchover_done_i)))
      else $error("switchover output mismatch");

   AST_OVERHEAT: assert property (
      (r.sel[0] == 6'h30) |=> (collector_out_1_o == $past(overheat_pt100_i)))
      else $error("overheat output mismatch");

   AST_STOPPED: assert property (
      (r.sel[3] == 6'h33) |=> (relay_out_2_o == $past(stopped_zero_i)))
      else $error("stopped output mismatch");

   AST_DISCONNECT: assert property (
      (r.sel[0] == 6'h34) |=>
      (collector_out_1_o == ($past(tension_disc_en_i) && $past(tension_disc_i))))
      else $error("disconnection output mismatch");

   AST_ROLL_MAX: assert property (
      (r.sel[2] == 6'h36) |=>
      (relay_out_1_o == ($past(tension_run_i) && $past(roll_max_i))))
      else $error("roll diameter output mismatch");

   AST_FIRE: assert property (
      (r.sel[0] == 6'h38) |=> (collector_out_1_o == $past(fire_mode_i)))
      else $error("fire mode output mismatch");

endmodule : ots_select
`default_nettype wire

// ===== test/ots_load.sv
// model of the equipment wired to the four output terminals
`timescale 1ns/100ps
`default_nettype none
module ots_load (
   input  wire logic [3:0] pin_i,
   output      logic [3:0] seen_o
);
   // the load only reads the terminals; contact bounce is not modelled
   assign seen_o = pin_i;
endmodule : ots_load
`default_nettype wire

// ===== test/output_terminal_function_select_tb.sv
// self-checking bench for the output terminal function selector
`timescale 1ns/100ps
`default_nettype none
module output_terminal_function_select_tb;
   import ots_pkg::*;
   localparam int unsigned MS_CYC = 8;
   localparam int unsigned Z_CYC  = 20;
   typedef struct {
      int        due;
      bit        kind;
      ots_data_t exp;
   } ots_note_t;
   logic             core_clk;
   logic             reset_n;
   ots_addr_t        addr;
   ots_data_t        wdata;
   logic             wr;
   logic             rd;
   wire ots_data_t   rdata;
   logic [63:0]      s;
   wire logic [3:0]  pin;
   wire logic [3:0]  seen;
   ots_code_t        sel [4];
   logic             ft;
   int               cyc = 0;
   int               num_errors;
   int               check_count;
   ots_note_t        notes [$];

   // condition inputs sit at the bit of their code; spare bits carry the gating inputs
   ots_select #(.MS_CYC(MS_CYC), .Z_CYC(Z_CYC)) u_ots_select (
      .core_clk_i(core_clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .run_freq_i(s[1]), .run_fwd_i(s[2]), .run_rev_i(s[3]),
      .jog_i(s[4]), .fault_i(s[5]), .fdt1_i(s[6]), .fdt2_i(s[7]), .freq_reached_i(s[8]),
      .zero_speed_run_i(s[9]), .upper_lim_i(s[10]), .lower_lim_i(s[11]), .ready_i(s[12]),
      .pre_excite_i(s[13]), .overload_i(s[14]), .underload_i(s[15]), .seq_stage_done_i(s[16]),
      .seq_cycle_done_i(s[17]), .count_set_i(s[18]), .count_desig_i(s[19]), .ext_fault_i(s[20]),
      .run_time_i(s[22]), .vbit_serial_i(s[23]), .vbit_fieldbus_i(s[24]), .vbit_eth_i(s[25]),
      .dc_bus_ok_i(s[26]), .enc_index_i(s[27]), .pulse_superpos_i(s[28]),
      .safe_torque_off_i(s[29]), .pos_done_i(s[30]), .spindle_zero_i(s[31]),
      .spindle_div_i(s[32]), .speed_limit_i(s[33]), .vbit_indeth_i(s[34]),
      .switchover_done_i(s[36]), .ramp_above_i(s[37]), .expansion_card_i(s[47:41]),
      .overheat_pt100_i(s[48]), .overheat_pt1000_i(s[49]), .overheat_aio_i(s[50]),
      .stopped_zero_i(s[51]), .tension_disc_en_i(s[21]), .tension_disc_i(s[52]),
      .tension_run_i(s[35]), .roll_set_i(s[53]), .roll_max_i(s[54]), .roll_min_i(s[55]),
      .fire_mode_i(s[56]), .pulse_stream_i(s[38]), .collector_out_1_o(pin[0]),
      .fast_pulse_out_o(pin[1]), .relay_out_1_o(pin[2]), .relay_out_2_o(pin[3])
   );
   ots_load u_ots_load (.pin_i(pin), .seen_o(seen));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   function automatic logic [63:0] conds(input logic [63:0] v);
      logic [63:0] c;
      c = v;
      c[0] = 1'b0;
      c[21] = 1'b0;
      c[35] = 1'b0;
      c[40:38] = 3'h0;
      c[63:57] = 7'h00;
      c[52] = v[52] & v[21];
      c[55:53] = v[55:53] & {3{v[35]}};
      return c;
   endfunction : conds

   function automatic logic [3:0] expect_pins(input logic [63:0] v);
      logic [63:0] c;
      logic [3:0]  e;
      c = conds(v);
      for (int i = 0; i < 4; i++) e[i] = c[sel[i]];
      if (!ft) e[1] = v[38];
      return e;
   endfunction : expect_pins

   task automatic check(input string what, input ots_data_t got, input ots_data_t exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic note(input bit kind, input ots_data_t exp, input int lat);
      notes.push_back('{cyc + lat, kind, exp});
   endtask : note

   task automatic drive(input logic [63:0] v, input logic [3:0] e, input int lat);
      @(posedge core_clk);
      s  <= v;
      wr <= 1'b0;
      rd <= 1'b0;
      if (lat > 0) note(1'b0, {28'h0, e}, lat);
   endtask : drive

   task automatic wr_reg(input ots_addr_t a, input ots_data_t d);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      rd    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input ots_addr_t a, input ots_data_t e);
      @(posedge core_clk);
      addr <= a;
      wr   <= 1'b0;
      rd   <= 1'b1;
      note(1'b1, e, 2);
   endtask : rd_reg

   task automatic print_verdict();
      if (notes.size() > 0) num_errors++;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict

   always @(posedge core_clk) cyc <= cyc + 1;

   // oldest note first; both kinds may fall due in one cycle
   always @(negedge core_clk) begin : monitor
      ots_note_t n;
      while (notes.size() > 0 && notes[0].due <= cyc) begin
         n = notes.pop_front();
         if (n.kind) check("rdata", rdata, n.exp);
         else check("pins", {28'h0, seen}, n.exp);
      end
   end

   initial begin : main
      ots_addr_t   ra [9];
      ots_data_t   rv [9];
      logic [63:0] v;
      ots_code_t   code;
      int          n;
      int          tm;
      ra = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
      rv = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0};
      s = 64'h0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      reset_n = 1'b0;
      num_errors = 0;
      check_count = 0;
      sel = '{6'h00, 6'h00, 6'h01, 6'h05};
      ft = 1'b0;
      void'($urandom(32'h4a0b));
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      drive(64'h0, 4'h0, 2);
      for (int i = 0; i < 9; i++) rd_reg(ra[i], rv[i]);
      repeat (10) begin
         v = {$urandom, $urandom};
         drive(v, expect_pins(v), 2);
      end
      $display("test reset done");
      for (int r = 0; r < 18; r++) begin
         ft = ~r[0];
         wr_reg(8'h00, {31'h0, ft});
         for (int i = 0; i < 4; i++) begin
            code = (r == 17) ? 6'h0d : (r == 16) ? 6'h1d : ots_code_t'(4 * r + i);
            // stateful codes get their own scenarios below
            if (code == 6'h0e || code == 6'h0f || code == 6'h1b) code = code ^ 6'h20;
            sel[i] = code;
            v = {$urandom, $urandom};
            wr_reg(ots_addr_t'(4 * i + 4), {v[25:0], code});
            rd_reg(ots_addr_t'(4 * i + 4), {26'h0, code});
         end
         repeat (20) begin
            v = {$urandom, $urandom};
            drive(v, expect_pins(v), 2);
         end
      end
      $display("test select done");
      wr_reg(8'h00, 32'h1);
      wr_reg(8'h14, 32'h2);
      wr_reg(8'h18, 32'h0);
      for (int i = 1; i < 4; i++) wr_reg(ots_addr_t'(4 * i + 4), 32'h0);
      for (int k = 14; k < 16; k++) begin
         tm = (k == 14) ? 2 : 0;
         wr_reg(8'h04, ots_data_t'(k));
         repeat (3) drive(64'h0, 4'h0, 3);
         v = 64'h0;
         v[k] = 1'b1;
         drive(v, 4'h0, 0);
         n = 0;
         while (seen[0] !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
         end
         check("prealarm delay", ots_data_t'(n > tm * MS_CYC && n <= (tm + 1) * MS_CYC + 4),
               32'h1);
         if (n >= 100) print_verdict();
         rd_reg(8'h1c, (k == 14) ? 32'h11 : 32'h21);
         drive(64'h0, 4'h0, 3);
      end
      $display("test prealarm done");
      wr_reg(8'h04, 32'h1b);
      repeat (3) drive(64'h0, 4'h0, 3);
      for (int t = 0; t < Z_CYC + 6; t++) begin
         v = 64'h0;
         v[27] = (t < 3);
         drive(v, {3'h0, t >= 1 && t <= Z_CYC}, 2);
      end
      $display("test index done");
      repeat (4) @(posedge core_clk);
      print_verdict();
   end
endmodule : output_terminal_function_select_tb
`default_nettype wire
